// File: bench/rgcl_props.sv
// port checker for the gain control block
`timescale 1ns/1ps
`default_nettype none
module rgcl_props (
  input wire logic        i_ref_clk,
  input wire logic        i_reset_n,
  input wire logic        i_wb_cyc,
  input wire logic        i_wb_stb,
  input wire logic        i_wb_we,
  input wire logic [7:0]  i_wb_adr,
  input wire logic [31:0] o_wb_dat,
  input wire logic        o_wb_ack,
  input wire logic        i_rx_on,
  input wire logic [4:0]  o_gain,
  input wire logic        o_carrier
);
  logic       rq;
  logic       quiet;
  logic [2:0] ack_r;
  assign rq = i_wb_cyc && i_wb_stb;
  // no access acked in the last three cycles
  assign quiet = ack_r == 3'h0;
  always_ff @(posedge i_ref_clk) begin
    ack_r <= i_reset_n ? {ack_r[1:0], o_wb_ack} : 3'h0;
  end
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);
  a_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack too long");
  a_ack_cause: assert property (rq && !o_wb_ack |=> o_wb_ack)
    else $error("no ack");
  a_no_stray_ack: assert property (!rq |=> !o_wb_ack)
    else $error("stray ack");
  a_dat_upper: assert property (o_wb_ack |-> o_wb_dat[31:8] == 24'h0)
    else $error("upper data set");
  a_unmapped_zero: assert property (o_wb_ack && !i_wb_we &&
    (i_wb_adr < 8'h12 || i_wb_adr > 8'h16) |-> o_wb_dat == 32'h0)
    else $error("unmapped read");
  a_gain_one_step: assert property (
    quiet && i_rx_on && $past(i_rx_on) && $past(i_rx_on, 2) &&
    $changed(o_gain) |->
    o_gain == $past(o_gain) + 5'h1 || o_gain == $past(o_gain) - 5'h1)
    else $error("gain jump");
  a_carrier_rx_off: assert property (
    !i_rx_on [*3] |-> !o_carrier)
    else $error("carrier while off");
  a_gain_hold_off: assert property (
    !i_rx_on [*3] ##0 quiet |-> $stable(o_gain))
    else $error("gain moved while off");
  c_read: cover property (o_wb_ack && !i_wb_we);
  c_gain: cover property (i_rx_on && $changed(o_gain));
  c_car: cover property ($rose(o_carrier));
endmodule
bind rgcl_top rgcl_props rgcl_props_inst (
  .i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_wb_cyc(i_wb_cyc),
  .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
  .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_rx_on(i_rx_on),
  .o_gain(o_gain), .o_carrier(o_carrier));
`default_nettype wire

// File: bench/tb_top.sv
// self-checking bench for the gain control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import rgcl_pkg::*;
  logic        clk, rst_n, cyc, stb, we, rx, mv, ack, car;
  logic [7:0]  adr, mag;
  logic [31:0] wd, rdat, q;
  logic [4:0]  gain, g;
  logic [1:0]  amp2;
  int          n_errors, n_tests;
  rgcl_amp2_t  ex [4] = '{RGCL_AMP2_MID, RGCL_AMP2_MIN, RGCL_AMP2_MED,
                          RGCL_AMP2_MAX};
  rgcl_top rgcl_top_inst (
    .i_ref_clk(clk), .i_reset_n(rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hf), .i_wb_dat(wd),
    .o_wb_dat(rdat), .o_wb_ack(ack), .i_rx_on(rx), .i_mag_valid(mv),
    .i_mag(mag), .o_gain(gain), .o_amp2(amp2), .o_carrier(car));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wd <= {24'h0, d};
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 20);
    chk({31'h0, ack}, 32'h1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rr(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h0);
    chk(q, {24'h0, e});
  endtask
  // n equal samples, a whole averaging window or part of one, then let outputs settle
  task automatic win(input logic [7:0] v, input int n);
    repeat (n) begin
      @(posedge clk);
      mv <= 1'b1;
      mag <= v;
      @(posedge clk);
      mv <= 1'b0;
    end
    repeat (4) @(posedge clk);
  endtask
  task automatic cg(input logic [4:0] e);
    chk({27'h0, gain}, {27'h0, e});
  endtask
  task automatic t_regs;
    cg(5'h18);
    rr(8'h12, 8'h75);
    rr(8'h13, 8'h38);
    rr(8'h14, 8'h38);
    bus(1'b1, 8'h20, 8'h5a);
    rr(8'h20, 8'h00);
    $display("regs done");
  endtask
  task automatic t_off;
    bus(1'b1, 8'h12, 8'h48);
    bus(1'b1, 8'h13, 8'h07);
    bus(1'b1, 8'h14, 8'h0a);
    rx <= 1'b1;
    win(8'hff, 2);
    cg(5'h07);
    bus(1'b1, 8'h13, 8'h14);
    repeat (3) @(posedge clk);
    cg(5'h14);
    $display("off done");
  endtask
  // reference 10, up offset 0: down above 13 plus margin code
  task automatic t_down;
    g = 5'h14;
    for (int c = 0; c < 4; c++) begin
      bus(1'b1, 8'h12, 8'h40 | 8'(c));
      win(8'h0e, (2 << c) - 1);
      cg(g);
      win(8'h0e, 1);
      g--;
      cg(g);
    end
    bus(1'b1, 8'h12, 8'h40);
    for (int m = 0; m < 8; m++) begin
      bus(1'b1, 8'h13, {3'(m), 5'h14});
      win(8'(13 + m), 2);
      cg(g);
      win(8'(14 + m), 2);
      g--;
      cg(g);
    end
    $display("down done");
  endtask
  task automatic t_up;
    for (int u = 0; u < 8; u++) begin
      bus(1'b1, 8'h14, {3'(u), 5'h0a});
      win(8'(10 + u), 2);
      cg(g);
      win(8'(9 + u), 2);
      g++;
      cg(g);
    end
    bus(1'b1, 8'h13, 8'h11);
    win(8'h00, 2);
    win(8'h00, 2);
    cg(5'h11);
    $display("up done");
  endtask
  task automatic t_confirm;
    bus(1'b1, 8'h12, 8'h44);
    win(8'hff, 2);
    cg(5'h11);
    win(8'hff, 2);
    cg(5'h10);
    win(8'hff, 2);
    win(8'h00, 2);
    cg(5'h10);
    win(8'h00, 2);
    cg(5'h11);
    $display("confirm done");
  endtask
  task automatic t_car;
    bus(1'b1, 8'h12, 8'h40);
    bus(1'b1, 8'h14, 8'h0a);
    rx <= 1'b0;
    repeat (4) @(posedge clk);
    rx <= 1'b1;
    win(8'h0a, 2);
    chk({31'h0, car}, 32'h0);
    win(8'h0a, 2);
    chk({31'h0, car}, 32'h1);
    cg(5'h11);
    rr(8'h16, 8'hd1);
    $display("carrier done");
  endtask
  task automatic t_amp2;
    for (int s = 0; s < 4; s++) begin
      bus(1'b1, 8'h12, 8'h80 | 8'(s << 4));
      repeat (3) @(posedge clk);
      chk({30'h0, amp2}, {30'h0, ex[s]});
    end
    bus(1'b1, 8'h12, 8'h50);
    repeat (3) @(posedge clk);
    chk({30'h0, amp2}, {30'h0, RGCL_AMP2_MAX});
    bus(1'b1, 8'h12, 8'h60);
    repeat (3) @(posedge clk);
    chk({30'h0, amp2}, {30'h0, RGCL_AMP2_MIN});
    $display("amp2 done");
  endtask
  task automatic stop_test;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    #2ms;
    n_errors++;
    stop_test();
  end
  initial begin
    {rst_n, cyc, stb, we, rx, mv, adr, mag, wd} = '0;
    n_errors = 0;
    n_tests = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_off();
    t_down();
    t_up();
    t_confirm();
    t_car();
    t_amp2();
    stop_test();
  end
endmodule
`default_nettype wire

// File: hdl/rgcl_averager.sv
// magnitude averager over 2, 4, 8 or 16 samples
`timescale 1ns/1ps
`default_nettype none
module rgcl_averager
  import rgcl_pkg::*;
#(
  parameter int MAG_W = 8
) (
  input  wire logic             i_ref_clk,
  input  wire logic             i_reset_n,
  input  wire logic             i_clear,
  input  wire logic [1:0]       i_avg_len,
  input  wire logic             i_valid,
  input  wire logic [MAG_W-1:0] i_mag,
  output logic                  o_done,
  output logic [MAG_W-1:0]      o_avg
);
  logic [MAG_W+3:0] acc_r, acc_nxt;
  logic [3:0]       cnt_r, cnt_nxt;
  logic             done_r, done_nxt;
  logic [MAG_W-1:0] avg_r, avg_nxt;
  logic [3:0]       last;
  logic [MAG_W+3:0] sum;

  always_comb begin
    last     = 4'((5'h2 << i_avg_len) - 5'h1);
    sum      = acc_r + {4'h0, i_mag};
    acc_nxt  = acc_r;
    cnt_nxt  = cnt_r;
    done_nxt = 1'b0;
    avg_nxt  = avg_r;
    if (i_clear) begin
      acc_nxt = '0;
      cnt_nxt = 4'h0;
    end else if (i_valid) begin
      if (cnt_r >= last) begin
        done_nxt = 1'b1;
        // three-bit shift count, 16 samples need a shift of 4
        avg_nxt  = MAG_W'(sum >> ({1'b0, i_avg_len} + 3'd1));
        acc_nxt  = '0;
        cnt_nxt  = 4'h0;
      end else begin
        acc_nxt = sum;
        cnt_nxt = cnt_r + 4'h1;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      acc_r  <= '0;
      cnt_r  <= 4'h0;
      done_r <= 1'b0;
      avg_r  <= '0;
    end else begin
      acc_r  <= acc_nxt;
      cnt_r  <= cnt_nxt;
      done_r <= done_nxt;
      avg_r  <= avg_nxt;
    end
  end

  assign o_done = done_r;
  assign o_avg  = avg_r;
endmodule
`default_nettype wire

// File: hdl/rgcl_params.svh
// constants for the receiver gain control logic
`ifndef RGCL_PARAMS_SVH
`define RGCL_PARAMS_SVH
`define RGCL_OFS_STAGE      8'h12
`define RGCL_OFS_DOWN       8'h13
`define RGCL_OFS_UP         8'h14
`define RGCL_OFS_CTRL       8'h15
`define RGCL_OFS_STATUS     8'h16
`define RGCL_RST_STAGE      8'h75
`define RGCL_RST_GAIN       5'h18
`define RGCL_RST_DOWN       8'h38
`define RGCL_RST_UP         8'h38
`define RGCL_RST_CTRL       8'h01
`define RGCL_BIT_FLOOR      7
`define RGCL_BIT_CEIL       6
`define RGCL_POS_SWPT       4
`define RGCL_BIT_OFF        3
`define RGCL_BIT_CONFIRM    2
`define RGCL_POS_AVG        0
`define RGCL_POS_MARGIN     5
`define RGCL_POS_LEVEL      0
`define RGCL_GAIN_MAX       5'h1f
`define RGCL_SWPT_LOW       5'h0a
`define RGCL_SWPT_HIGH      5'h13
`endif

// File: hdl/rgcl_pkg.sv
// types for the receiver gain control logic
package rgcl_pkg;
  typedef enum logic [1:0] {
    RGCL_AMP2_MIN  = 2'b00,
    RGCL_AMP2_MED  = 2'b01,
    RGCL_AMP2_MAX  = 2'b10,
    RGCL_AMP2_MID  = 2'b11
  } rgcl_amp2_t;
  typedef enum logic [1:0] {
    RGCL_DEC_HOLD = 2'b00,
    RGCL_DEC_UP   = 2'b01,
    RGCL_DEC_DOWN = 2'b10
  } rgcl_dec_t;
endpackage

// File: hdl/rgcl_top.sv
// receiver gain control logic with wishbone register slave
//
// The Wishbone interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "rgcl_params.svh"
module rgcl_top
  import rgcl_pkg::*;
#(
  parameter int MAG_W = 8
) (
  input  wire logic             i_ref_clk,
  input  wire logic             i_reset_n,
  input  wire logic             i_wb_cyc,
  input  wire logic             i_wb_stb,
  input  wire logic             i_wb_we,
  input  wire logic [7:0]       i_wb_adr,
  input  wire logic [3:0]       i_wb_sel,
  input  wire logic [31:0]      i_wb_dat,
  output logic [31:0]           o_wb_dat,
  output logic                  o_wb_ack,
  input  wire logic             i_rx_on,
  input  wire logic             i_mag_valid,
  input  wire logic [MAG_W-1:0] i_mag,
  output logic [4:0]            o_gain,
  output logic [1:0]            o_amp2,
  output logic                  o_carrier
);
  // level units of 1.5 dB per step of the averaged magnitude
  logic [7:0]  stage_r, stage_nxt;
  logic [7:0]  down_r, down_nxt;
  logic [7:0]  up_r, up_nxt;
  logic [7:0]  ctrl_r, ctrl_nxt;
  logic        ack_r, ack_nxt;
  logic [31:0] rdat_r, rdat_nxt;
  logic [4:0]  gain_r, gain_nxt;
  logic [1:0]  amp2_r, amp2_nxt;
  logic        carr_r, carr_nxt;
  logic [1:0]  pend_r, pend_nxt;
  logic [2:0]  cs_cnt_r, cs_cnt_nxt;
  logic        avg_done;
  logic [MAG_W-1:0] avg;
  logic        wr;
  logic        rd;
  logic [MAG_W+1:0] up_lvl;
  logic [MAG_W+1:0] down_lvl;
  rgcl_dec_t   dec;

  wire logic       floor_sel = stage_r[`RGCL_BIT_FLOOR];
  wire logic       ceil_sel  = stage_r[`RGCL_BIT_CEIL];
  wire logic [1:0] swpt      = stage_r[`RGCL_POS_SWPT +: 2];
  wire logic       loop_off  = stage_r[`RGCL_BIT_OFF];
  wire logic       confirm   = stage_r[`RGCL_BIT_CONFIRM];
  wire logic [1:0] avg_len   = stage_r[`RGCL_POS_AVG +: 2];
  wire logic [2:0] margin    = down_r[`RGCL_POS_MARGIN +: 3];
  wire logic [4:0] start     = down_r[`RGCL_POS_LEVEL +: 5];
  wire logic [2:0] up_ofs    = up_r[`RGCL_POS_MARGIN +: 3];
  wire logic [4:0] ref_lvl   = up_r[`RGCL_POS_LEVEL +: 5];
  wire logic [1:0] cs_need   = ctrl_r[1:0];

  // byte lane 0 write of an 8-bit register
  function automatic logic [7:0] lane0(input logic [7:0] old,
                                       input logic       en);
    lane0 = (en && i_wb_sel[0]) ? i_wb_dat[7:0] : old;
  endfunction

  // second stage gain from gain setting and range bits
  function automatic logic [1:0] amp2_of(input logic [4:0] g);
    logic       hi;
    hi = 1'b0;
    unique case (swpt)
      2'd0: hi = 1'b1;
      2'd1: hi = g >= `RGCL_SWPT_LOW;
      2'd2: hi = g >= `RGCL_SWPT_HIGH;
      2'd3: hi = 1'b0;
    endcase
    if (floor_sel && !ceil_sel) begin
      unique case (swpt)
        2'd0: amp2_of = RGCL_AMP2_MID;
        2'd1: amp2_of = RGCL_AMP2_MIN;
        2'd2: amp2_of = RGCL_AMP2_MED;
        2'd3: amp2_of = RGCL_AMP2_MAX;
      endcase
    end else if (hi) begin
      amp2_of = ceil_sel ? RGCL_AMP2_MAX : RGCL_AMP2_MED;
    end else begin
      amp2_of = floor_sel ? RGCL_AMP2_MED : RGCL_AMP2_MIN;
    end
  endfunction

  rgcl_averager #(
    .MAG_W (MAG_W)
  ) u_avg (
    .i_ref_clk (i_ref_clk),
    .i_reset_n (i_reset_n),
    .i_clear   (!i_rx_on),
    .i_avg_len (avg_len),
    .i_valid   (i_mag_valid),
    .i_mag     (i_mag),
    .o_done    (avg_done),
    .o_avg     (avg)
  );

  // bus slave
  always_comb begin
    wr        = i_wb_cyc && i_wb_stb && i_wb_we && !ack_r;
    rd        = i_wb_cyc && i_wb_stb && !i_wb_we && !ack_r;
    ack_nxt   = i_wb_cyc && i_wb_stb && !ack_r;
    stage_nxt = lane0(stage_r, wr && i_wb_adr == `RGCL_OFS_STAGE);
    down_nxt  = lane0(down_r, wr && i_wb_adr == `RGCL_OFS_DOWN);
    up_nxt    = lane0(up_r, wr && i_wb_adr == `RGCL_OFS_UP);
    ctrl_nxt  = lane0(ctrl_r, wr && i_wb_adr == `RGCL_OFS_CTRL);
    rdat_nxt  = rdat_r;
    if (rd) begin
      unique case (i_wb_adr)
        `RGCL_OFS_STAGE:  rdat_nxt = {24'h0, stage_r};
        `RGCL_OFS_DOWN:   rdat_nxt = {24'h0, down_r};
        `RGCL_OFS_UP:     rdat_nxt = {24'h0, up_r};
        `RGCL_OFS_CTRL:   rdat_nxt = {24'h0, ctrl_r};
        `RGCL_OFS_STATUS: rdat_nxt = {21'h0, carr_r, amp2_r, gain_r};
        default:          rdat_nxt = 32'h0;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      stage_r <= `RGCL_RST_STAGE;
      down_r  <= `RGCL_RST_DOWN;
      up_r    <= `RGCL_RST_UP;
      ctrl_r  <= `RGCL_RST_CTRL;
      ack_r   <= 1'b0;
      rdat_r  <= 32'h0;
    end else begin
      stage_r <= stage_nxt;
      down_r  <= down_nxt;
      up_r    <= up_nxt;
      ctrl_r  <= ctrl_nxt;
      ack_r   <= ack_nxt;
      rdat_r  <= rdat_nxt;
    end
  end

  // gain loop
  always_comb begin
    up_lvl   = {2'b00, MAG_W'(ref_lvl)} + {2'b00, MAG_W'(up_ofs)};
    // (margin code 0 is 3 steps of 1.5 dB)
    down_lvl = up_lvl + {2'b00, MAG_W'(margin)} + (MAG_W+2)'(3);
    dec = RGCL_DEC_HOLD;
    if ({2'b00, avg} > down_lvl) begin
      dec = RGCL_DEC_DOWN;
    end else if ({2'b00, avg} < up_lvl && gain_r < start) begin
      dec = RGCL_DEC_UP;
    end
    gain_nxt   = gain_r;
    pend_nxt   = pend_r;
    cs_cnt_nxt = cs_cnt_r;
    carr_nxt   = carr_r;
    if (!i_rx_on || loop_off) begin
      gain_nxt   = start;
      pend_nxt   = RGCL_DEC_HOLD;
      cs_cnt_nxt = 3'h0;
      carr_nxt   = 1'b0;
    end else if (avg_done) begin
      pend_nxt = dec;
      if (dec != RGCL_DEC_HOLD && (!confirm || pend_r == dec)) begin
        pend_nxt = RGCL_DEC_HOLD;
        if (dec == RGCL_DEC_UP) begin
          gain_nxt = gain_r + 5'h1;
        end else if (gain_r != 5'h0) begin
          gain_nxt = gain_r - 5'h1;
        end
      end
      if ({2'b00, avg} >= {2'b00, MAG_W'(ref_lvl)}) begin
        if (cs_cnt_r < {1'b0, cs_need}) begin
          cs_cnt_nxt = cs_cnt_r + 3'h1;
        end else begin
          carr_nxt = 1'b1;
        end
      end else begin
        cs_cnt_nxt = 3'h0;
        carr_nxt   = 1'b0;
      end
    end
    amp2_nxt = amp2_of(gain_nxt);
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      gain_r   <= `RGCL_RST_GAIN;
      amp2_r   <= 2'h0;
      carr_r   <= 1'b0;
      pend_r   <= 2'h0;
      cs_cnt_r <= 3'h0;
    end else begin
      gain_r   <= gain_nxt;
      amp2_r   <= amp2_nxt;
      carr_r   <= carr_nxt;
      pend_r   <= pend_nxt;
      cs_cnt_r <= cs_cnt_nxt;
    end
  end

  assign o_wb_dat  = rdat_r;
  assign o_wb_ack  = ack_r;
  assign o_gain    = gain_r;
  assign o_amp2    = amp2_r;
  assign o_carrier = carr_r;
endmodule
`default_nettype wire
